// ==== include/rmx_defines.svh ====
`ifndef RMX_DEFINES_SVH
`define RMX_DEFINES_SVH
// Register byte offsets
`define RMX_MST_OFF      12'h000
`define RMX_SRA_OFF      12'h004
`define RMX_SSC_OFF      12'h008
`define RMX_STAT_OFF     12'h00C
`define RMX_MASK_OFF     12'h010
`define RMX_VEC_OFF      12'h014
// Machine state register fields
`define RMX_MST_RCV      1
`define RMX_MST_MCE      12
`define RMX_MST_PR       14
`define RMX_MST_EE       15
`define RMX_MST_RST      32'h00000000
// Exception vector offsets
`define RMX_VEC_RSV      20'h00000
`define RMX_VEC_RESET    20'h00100
`define RMX_VEC_MCHK     20'h00200
// Status bits
`define RMX_ST_RESET     0
`define RMX_ST_MCHK      1
`define RMX_ST_CHKSTOP   2
`define RMX_ST_W         3
// Bus operation kinds
`define RMX_OP_READ      2'h0
`define RMX_OP_WRITE     2'h1
`define RMX_OP_FETCH     2'h2
`define RMX_OP_OTHER     2'h3
`endif

// ==== include/rmx_pkg.sv ====
package rmx_pkg;
  typedef enum logic [1:0] {
    RMX_RUN     = 2'b01,
    RMX_CHKSTOP = 2'b10
  } rmx_state_t;
endpackage

// ==== logic/rmx_exc_unit.sv ====
// Summary of operation
// - Reset pin assertion takes vector 00100
// - Corrupted state clears saved recoverable indicator
// - Qualified error ack or input: vector 00200
// - Machine check with enable clear: checkstop
// - Any taken exception clears check enable
// - Bus or cache parity raises machine check
// - Machine check imprecise; saves current address
// - Error ack sampled only for own operations
// - Save state, fetch vector, supervisor mode
// - Reset, machine check ignore interrupt enable
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "rmx_defines.svh"
module rmx_exc_unit
  import rmx_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // External pins
  input  wire logic              soft_reset_pin,
  input  wire logic              hard_reset_pin,
  input  wire logic              transfer_error_ack,
  input  wire logic              machine_check_input,
  // Core-side status
  input  wire logic              bus_op_valid,
  input  wire logic [1:0]        bus_op_kind,
  input  wire logic [31:0]       cur_pc,
  input  wire logic              state_corrupt,
  input  wire logic              addr_par_err,
  input  wire logic              data_par_err,
  input  wire logic              icache_par_err,
  input  wire logic              dcache_par_err,
  // Exception outputs
  output logic                   exc_take,
  output logic [19:0]            exc_vector,
  output logic [31:0]            saved_return_address,
  output logic [31:0]            saved_status_copy,
  output logic [31:0]            machine_state_register,
  output logic                   checkstop,
  output logic                   irq
);

  // Offsets reach 0x14, so five address bits at least
  if (ADDR_W < 5) begin : g_addr_chk
    $error("ADDR_W too small for register map");
  end

  // Pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  logic [3:0] pin_raw;
  assign pin_raw = {machine_check_input, transfer_error_ack, hard_reset_pin, soft_reset_pin};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic rst_lvl;
  logic rst_lvl_q;
  logic rst_ev;
  logic bus_qual;
  logic err_ack_ev;
  logic mci_ev;
  logic par_ev;
  logic mc_cond;
  assign rst_lvl   = pin_s2_r[0] | pin_s2_r[1];
  assign rst_lvl_q = pin_s3_r[0] | pin_s3_r[1];
  assign rst_ev    = rst_lvl & ~rst_lvl_q;
  assign bus_qual  = bus_op_valid & (bus_op_kind != `RMX_OP_OTHER);
  assign err_ack_ev = pin_s2_r[2] & bus_qual;
  assign mci_ev     = pin_s2_r[3] & ~pin_s3_r[3];
  assign par_ev    = addr_par_err | data_par_err | icache_par_err | dcache_par_err;
  assign mc_cond   = err_ack_ev | mci_ev | par_ev;

  // Exception state
  rmx_state_t  state_r, state_nxt;
  logic [31:0] mst_r, mst_nxt;
  logic [31:0] sra_r, sra_nxt;
  logic [31:0] ssc_r, ssc_nxt;
  logic [19:0] vec_r, vec_nxt;
  logic        take_r, take_nxt;
  logic [`RMX_ST_W-1:0] stat_r, stat_nxt;
  logic [`RMX_ST_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_acc;
  logic rd_setup;
  logic mapped;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == ADDR_W'(`RMX_MST_OFF)) || (paddr == ADDR_W'(`RMX_SRA_OFF))
                 || (paddr == ADDR_W'(`RMX_SSC_OFF)) || (paddr == ADDR_W'(`RMX_STAT_OFF))
                 || (paddr == ADDR_W'(`RMX_MASK_OFF)) || (paddr == ADDR_W'(`RMX_VEC_OFF));

  always_comb begin
    state_nxt = state_r;
    mst_nxt   = mst_r;
    sra_nxt   = sra_r;
    ssc_nxt   = ssc_r;
    vec_nxt   = vec_r;
    take_nxt  = 1'b0;
    stat_nxt  = stat_r;
    mask_nxt  = mask_r;
    rdata_nxt = rdata_r;
    // Software writes; a take in the same cycle overrides below
    if (wr_acc) begin
      if (paddr == ADDR_W'(`RMX_MST_OFF)) begin
        mst_nxt = pwdata;
      end else if (paddr == ADDR_W'(`RMX_STAT_OFF)) begin
        stat_nxt = stat_r & ~pwdata[`RMX_ST_W-1:0];
      end else if (paddr == ADDR_W'(`RMX_MASK_OFF)) begin
        mask_nxt = pwdata[`RMX_ST_W-1:0];
      end
    end
    case (state_r)
      RMX_RUN: begin
        if (rst_ev) begin
          take_nxt = 1'b1;
          vec_nxt  = `RMX_VEC_RESET;
          stat_nxt[`RMX_ST_RESET] = 1'b1;
        end else if (mc_cond) begin
          if (!mst_r[`RMX_MST_MCE]) begin
            state_nxt = RMX_CHKSTOP;
            stat_nxt[`RMX_ST_CHKSTOP] = 1'b1;
          end else begin
            take_nxt = 1'b1;
            vec_nxt  = `RMX_VEC_MCHK;
            stat_nxt[`RMX_ST_MCHK] = 1'b1;
          end
        end
      end
      RMX_CHKSTOP: begin
        // Only a system reset leaves checkstop
        if (rst_ev) begin
          state_nxt = RMX_RUN;
          take_nxt  = 1'b1;
          vec_nxt   = `RMX_VEC_RESET;
          stat_nxt[`RMX_ST_RESET] = 1'b1;
        end
      end
      default: begin
        state_nxt = RMX_RUN;
      end
    endcase
    if (take_nxt) begin
      sra_nxt = cur_pc;
      ssc_nxt = mst_r;
      ssc_nxt[`RMX_MST_RCV] = mst_r[`RMX_MST_RCV] & ~state_corrupt;
      mst_nxt = mst_r;
      mst_nxt[`RMX_MST_MCE] = 1'b0;
      mst_nxt[`RMX_MST_PR] = 1'b0;
      mst_nxt[`RMX_MST_EE] = 1'b0;
    end
    if (rd_setup) begin
      if (paddr == ADDR_W'(`RMX_MST_OFF)) begin
        rdata_nxt = mst_r;
      end else if (paddr == ADDR_W'(`RMX_SRA_OFF)) begin
        rdata_nxt = sra_r;
      end else if (paddr == ADDR_W'(`RMX_SSC_OFF)) begin
        rdata_nxt = ssc_r;
      end else if (paddr == ADDR_W'(`RMX_STAT_OFF)) begin
        rdata_nxt = {29'h0, stat_r};
      end else if (paddr == ADDR_W'(`RMX_MASK_OFF)) begin
        rdata_nxt = {29'h0, mask_r};
      end else if (paddr == ADDR_W'(`RMX_VEC_OFF)) begin
        rdata_nxt = {11'h0, (state_r == RMX_CHKSTOP), vec_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= RMX_RUN;
      mst_r   <= `RMX_MST_RST;
      sra_r   <= 32'h00000000;
      ssc_r   <= 32'h00000000;
      vec_r   <= `RMX_VEC_RESET;
      take_r  <= 1'b0;
      stat_r  <= 3'h0;
      mask_r  <= 3'h0;
      rdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      mst_r   <= mst_nxt;
      sra_r   <= sra_nxt;
      ssc_r   <= ssc_nxt;
      vec_r   <= vec_nxt;
      take_r  <= take_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Zero-wait slave; read data captured in setup phase
  assign prdata                 = rdata_r;
  assign pready                 = 1'b1;
  assign pslverr                = psel & penable & ~mapped;
  assign exc_take               = take_r;
  assign exc_vector             = vec_r;
  assign saved_return_address   = sra_r;
  assign saved_status_copy      = ssc_r;
  assign machine_state_register = mst_r;
  assign checkstop              = (state_r == RMX_CHKSTOP);
  assign irq                    = |(stat_r & mask_r);

  property p_rst_vec;
    @(posedge clock) disable iff (!rst_n)
    rst_ev |=> exc_take && (exc_vector == 20'h00100);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset not taken at 00100");

  property p_ri_copy;
    @(posedge clock) disable iff (!rst_n)
    (take_nxt && state_corrupt) |=> !saved_status_copy[`RMX_MST_RCV];
  endproperty
  a_ri_copy: assert property (p_ri_copy) else $error("recoverable copy not cleared");

  property p_mc_vec;
    @(posedge clock) disable iff (!rst_n)
    (state_r == RMX_RUN && !rst_ev && (err_ack_ev || mci_ev) && mst_r[`RMX_MST_MCE])
      |=> exc_take && (exc_vector == 20'h00200) && !checkstop;
  endproperty
  a_mc_vec: assert property (p_mc_vec) else $error("machine check not taken");

  property p_chkstop;
    @(posedge clock) disable iff (!rst_n)
    (state_r == RMX_RUN && !rst_ev && mc_cond && !mst_r[`RMX_MST_MCE])
      |=> checkstop && !exc_take ##1 (checkstop || $past(rst_ev));
  endproperty
  a_chkstop: assert property (p_chkstop) else $error("checkstop not entered");

  property p_mce_clr;
    @(posedge clock) disable iff (!rst_n)
    exc_take |-> !machine_state_register[`RMX_MST_MCE]
      && saved_status_copy[`RMX_MST_MCE] == $past(mst_r[`RMX_MST_MCE]);
  endproperty
  a_mce_clr: assert property (p_mce_clr) else $error("check enable not cleared");

  property p_parity;
    @(posedge clock) disable iff (!rst_n)
    (state_r == RMX_RUN && !rst_ev && par_ev && mst_r[`RMX_MST_MCE])
      |=> exc_take && (exc_vector == 20'h00200);
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not taken");

  property p_save_pc;
    @(posedge clock) disable iff (!rst_n)
    $rose(take_r) |-> saved_return_address == $past(cur_pc);
  endproperty
  a_save_pc: assert property (p_save_pc) else $error("return address not saved");

  property p_tea_qual;
    @(posedge clock) disable iff (!rst_n)
    (state_r == RMX_RUN && !rst_ev && !mci_ev && !par_ev && !bus_qual)
      |=> !exc_take && !$rose(checkstop);
  endproperty
  a_tea_qual: assert property (p_tea_qual) else $error("unqualified error ack acted on");

  property p_super;
    @(posedge clock) disable iff (!rst_n)
    exc_take |-> !machine_state_register[`RMX_MST_PR] && !machine_state_register[`RMX_MST_EE];
  endproperty
  a_super: assert property (p_super) else $error("not in supervisor mode");

  property p_nomask;
    @(posedge clock) disable iff (!rst_n)
    (state_r == RMX_RUN && mc_cond && !mst_r[`RMX_MST_EE] && mst_r[`RMX_MST_MCE]) |=> exc_take;
  endproperty
  a_nomask: assert property (p_nomask) else $error("masked by interrupt enable");

  property p_nz_vec;
    @(posedge clock) disable iff (!rst_n)
    exc_take |-> exc_vector != 20'h00000;
  endproperty
  a_nz_vec: assert property (p_nz_vec) else $error("reserved vector selected");

endmodule // rmx_exc_unit

// ==== test/reset_machine_check_exception_unit_tb_top.sv ====
`timescale 1ns/1ps
`include "rmx_defines.svh"
module reset_machine_check_exception_unit_tb_top
  import rmx_pkg::*;
;
  localparam logic [31:0] MCE_BIT = 32'h1 << `RMX_MST_MCE;
  localparam logic [31:0] RCV_BIT = 32'h1 << `RMX_MST_RCV;
  localparam logic [31:0] PC      = 32'h00001A40;
  logic        clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, saved_return_address, saved_status_copy;
  logic [31:0] machine_state_register, rd, cur_pc = PC;
  logic        pready, pslverr, exc_take, checkstop, irq, got, er;
  logic        soft_reset_pin = 1'h0, hard_reset_pin = 1'h0, machine_check_input = 1'h0;
  logic        addr_par_err = 1'h0, data_par_err = 1'h0, icache_par_err = 1'h0;
  logic        dcache_par_err = 1'h0, report_err = 1'h0, rogue = 1'h0;
  logic        bus_op_valid = 1'h0, state_corrupt = 1'h0, transfer_error_ack;
  logic [1:0]  bus_op_kind = 2'h0;
  logic [19:0] exc_vector;
  int          mismatches = 0, n_checks = 0, cyc = 0;

  rmx_exc_unit i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .soft_reset_pin, .hard_reset_pin, .transfer_error_ack,
    .machine_check_input, .bus_op_valid, .bus_op_kind, .cur_pc, .state_corrupt,
    .addr_par_err, .data_par_err, .icache_par_err, .dcache_par_err, .exc_take,
    .exc_vector, .saved_return_address, .saved_status_copy, .machine_state_register,
    .checkstop, .irq);
  rmx_mem_ctrl_model i_mem (.clock, .rst_n, .bus_op_valid, .bus_op_kind, .report_err,
    .rogue, .transfer_error_ack);

  always #25 clock = ~clock;

  task end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, the run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One-cycle events; pins are edge-seen, parity and error are level-seen
  task fire(input logic [7:0] ev, output logic hit);
    hit = 1'h0;
    @(posedge clock);
    {report_err, dcache_par_err, icache_par_err, data_par_err, addr_par_err,
     machine_check_input, hard_reset_pin, soft_reset_pin} <= ev;
    @(posedge clock);
    {report_err, dcache_par_err, icache_par_err, data_par_err, addr_par_err,
     machine_check_input, hard_reset_pin, soft_reset_pin} <= 8'h00;
    // A parity take lands on the edge that clears the event, so look there first
    repeat (10) begin
      #1;
      if (exc_take === 1'h1) hit = 1'h1;
      @(posedge clock);
    end
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    apb(1'h0, `RMX_MST_OFF, 32'h0, rd, er);
    chk(rd, 32'h0);
    fire(8'h01, got);
    chk({31'h0, got}, 32'h1);
    chk({12'h0, exc_vector}, {12'h0, `RMX_VEC_RESET});
    chk(saved_return_address, PC);
    chk(machine_state_register & MCE_BIT, 32'h0);
    apb(1'h1, `RMX_MST_OFF, MCE_BIT | RCV_BIT, rd, er);
    fire(8'h04, got);
    chk({31'h0, got}, 32'h1);
    chk({12'h0, exc_vector}, {12'h0, `RMX_VEC_MCHK});
    chk(saved_status_copy & RCV_BIT, RCV_BIT);
    chk(machine_state_register & MCE_BIT, 32'h0);
    // Enable still clear from the last take
    fire(8'h08, got);
    chk({31'h0, got}, 32'h0);
    chk({31'h0, checkstop}, 32'h1);
    apb(1'h0, `RMX_VEC_OFF, 32'h0, rd, er);
    chk(rd, {11'h0, 1'h1, `RMX_VEC_MCHK});
    apb(1'h1, `RMX_MST_OFF, MCE_BIT | RCV_BIT, rd, er);
    state_corrupt <= 1'h1;
    fire(8'h02, got);
    state_corrupt <= 1'h0;
    chk({31'h0, got}, 32'h1);
    chk({31'h0, checkstop}, 32'h0);
    chk(saved_status_copy & RCV_BIT, 32'h0);
    for (int i = 3; i < 7; i++) begin
      cur_pc <= PC + 32'(i);
      apb(1'h1, `RMX_MST_OFF, MCE_BIT, rd, er);
      fire(8'h01 << i, got);
      chk({31'h0, got}, 32'h1);
      chk({12'h0, exc_vector}, {12'h0, `RMX_VEC_MCHK});
      apb(1'h0, `RMX_SRA_OFF, 32'h0, rd, er);
      chk(rd, PC + 32'(i));
    end
    bus_op_valid <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      bus_op_kind <= k[1:0];
      rogue <= (k == 3);
      apb(1'h1, `RMX_MST_OFF, MCE_BIT, rd, er);
      fire(8'h80, got);
      chk({31'h0, got}, 32'(k != 3));
    end
    bus_op_valid <= 1'h0;
    rogue <= 1'h0;
    apb(1'h1, `RMX_MASK_OFF, 32'h7, rd, er);
    @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `RMX_STAT_OFF, 32'h7, rd, er);
    @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, 12'hFFC, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    end_of_test;
  end
endmodule // reset_machine_check_exception_unit_tb_top

// ==== test/rmx_mem_ctrl_model.sv ====
`timescale 1ns/1ps
`include "rmx_defines.svh"
module rmx_mem_ctrl_model
  import rmx_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bus operation seen by the controller
  input  wire logic       bus_op_valid,
  input  wire logic [1:0] bus_op_kind,
  // Bench commands: report one error, ignore qualification
  input  wire logic       report_err,
  input  wire logic       rogue,
  // Error line
  output logic            transfer_error_ack
);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transfer_error_ack <= 1'h0;
    end else begin
      transfer_error_ack <= report_err
        && (rogue || (bus_op_valid && bus_op_kind != `RMX_OP_OTHER));
    end
  end
endmodule // rmx_mem_ctrl_model
